// ==== verilog/mmu_fault_consts.vh ====
// constants for the access fault checker
`ifndef MMU_FAULT_CONSTS_VH
`define MMU_FAULT_CONSTS_VH
`define ADDR_CONTROL      4'h0
`define ADDR_DOMAIN_CTRL  4'h1
`define ADDR_FAULT_STATUS 4'h2
`define ADDR_FAULT_ADDR   4'h3
`define CTL_MMU_EN        0
`define CTL_ALIGN_EN      1
`define CTL_CACHE_EN      2
`define CTL_WBUF_EN       3
`define CTL_SYS_PROT      8
`define CTL_ROM_PROT      9
`define CONTROL_RESET     32'h00000000
`define DOMAIN_RESET      32'h00000000
`define FS_WBUF           4'h0
`define FS_LINE_SECT      4'h4
`define FS_LINE_PAGE      4'h6
`define FS_BUS_SECT       4'h8
`define FS_BUS_PAGE       4'ha
`define FS_ALIGN          4'h1
`define FS_BUS_L1         4'hc
`define FS_BUS_L2         4'he
`define FS_XLAT_SECT      4'h5
`define FS_XLAT_PAGE      4'h7
`define FS_DOM_SECT       4'h9
`define FS_DOM_PAGE       4'hb
`define FS_PERM_SECT      4'hd
`define FS_PERM_PAGE      4'hf
`define KIND_UNCACHED     3'h0
`define KIND_UNBUF_WR     3'h1
`define KIND_L1_FETCH     3'h2
`define KIND_L2_FETCH     3'h3
`define KIND_LOCKED_RD    3'h4
`define KIND_LINEFILL     3'h5
`define KIND_BUF_WR       3'h6
`endif

// ==== verilog/mmu_fault_checker.v ====
// access fault checker with fault status, fault address and external abort handling
// How it works
// - alignment enabled by control bit 1 faults word data accesses with addr[1:0] nonzero
// - an alignment fault aborts at once and skips every later check
// - level one type 00 or 11 gives a section translation fault
// - level two type 00 or 11 gives a page translation fault
// - 4-bit descriptor domain picks one 2-bit entry of the domain word
// - section domain checked on level one return, page domain on level two return
// - domain entry 00 or 10 gives section or page domain fault
// - permission judged in the domain step, only when the entry is 01
// - section access bits read through control bits 8 and 9 give section permission faults
// - page quarter picks the permission field, 1Kb small, 16Kb large, top is highest
// - sub-page field read as a section one, reported as sub-page permission fault
// - aborted uncached read, unbuffered write or descriptor fetch stops next cycle
// - an aborted locked read suppresses the following write
// - abort on line fill word 0 leaves the cache unwritten
// - aborted line fill still runs all its bus words
// - aborted buffered write is logged in fault status and needs a reset
// - aborted buffered write burst still completes every beat
// - translation cache contents survive disabling and re-enabling translation
// - a data abort loads fault code, domain and the faulting address, the address not on a buffered write abort
// - a prefetch abort leaves fault status and address unchanged
// - domain entry 11 skips permission checks
`timescale 1ns/1ns
`default_nettype none
`include "mmu_fault_consts.vh"
module mmu_fault_checker
(
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  // access check request from the core
  input  wire        chk_valid,
  input  wire [31:0] chk_vaddr,
  input  wire        chk_is_fetch,
  input  wire        chk_is_byte,
  input  wire        chk_is_write,
  input  wire        chk_user,
  input  wire        chk_is_page,
  input  wire        chk_large_page,
  input  wire [31:0] chk_l1_desc,
  input  wire [31:0] chk_l2_desc,
  // check answer, one cycle after the request
  output reg         chk_done,
  output reg         chk_abort,
  output reg  [3:0]  chk_fault_code,
  // external abort side
  input  wire        ext_access,
  input  wire [2:0]  ext_kind,
  input  wire        ext_abort,
  input  wire [1:0]  ext_word,
  input  wire [3:0]  ext_domain,
  input  wire [31:0] ext_vaddr,
  output reg         ext_stop,
  output reg         lock_write_block,
  output reg         cache_write_block,
  output reg         wbuf_fatal,
  // enables seen by the rest of the core
  output wire        mmu_enable,
  output wire        cache_enable,
  output wire        write_buffer_enable,
  output wire        tlb_keep
);

  reg [31:0] control;
  reg [31:0] domain_word;
  reg [3:0]  fault_code;
  reg [3:0]  fault_domain;
  reg [31:0] fault_address_word;

  assign mmu_enable          = control[`CTL_MMU_EN];
  assign cache_enable        = control[`CTL_CACHE_EN];
  assign write_buffer_enable = control[`CTL_WBUF_EN];
  // translation cache is never flushed by the enable bit, only by software
  assign tlb_keep            = 1'b1;

  // permission judgement shared by sections and sub-pages
  function perm_ok;
    input [1:0] perm_bits;
    input       user;
    input       wr;
    input       s_bit;
    input       r_bit;
    begin
      case (perm_bits)
        2'b00:   perm_ok = wr ? 1'b0 : (s_bit ? !user : (r_bit ? 1'b1 : 1'b0));
        2'b01:   perm_ok = !user;
        2'b10:   perm_ok = !user || !wr;
        default: perm_ok = 1'b1;
      endcase
    end
  endfunction

  reg [3:0] next_code;
  reg       next_fault;
  reg [3:0] dom_sel;
  reg [1:0] dom_entry;
  reg [1:0] quarter;
  reg [1:0] page_perm;
  reg       misaligned;

  always @*
  begin
    next_code  = 4'h0;
    next_fault = 1'b0;
    dom_sel    = chk_l1_desc[8:5];
    dom_entry  = domain_word[{dom_sel, 1'b0} +: 2];
    // 1Kb quarters of a small page, 16Kb quarters of a large one
    quarter    = chk_large_page ? chk_vaddr[15:14] : chk_vaddr[11:10];
    // bottom quarter field sits at [5:4], each higher quarter two bits up
    page_perm  = chk_l2_desc[{quarter, 1'b0} + 4'h4 +: 2];
    misaligned = control[`CTL_ALIGN_EN] && !chk_is_fetch && !chk_is_byte
                 && (chk_vaddr[1:0] != 2'b00);
    if (misaligned)
    begin
      // later checks are skipped entirely
      next_fault = 1'b1;
      next_code  = `FS_ALIGN;
    end
    else if (control[`CTL_MMU_EN])
    begin
      if (chk_l1_desc[1:0] == 2'b00 || chk_l1_desc[1:0] == 2'b11)
      begin
        next_fault = 1'b1;
        next_code  = `FS_XLAT_SECT;
      end
      else if (chk_is_page && (chk_l2_desc[1:0] == 2'b00 || chk_l2_desc[1:0] == 2'b11))
      begin
        next_fault = 1'b1;
        next_code  = `FS_XLAT_PAGE;
      end
      else if (dom_entry == 2'b00 || dom_entry == 2'b10)
      begin
        // page domain only judged once the level two entry is in hand
        next_fault = 1'b1;
        next_code  = chk_is_page ? `FS_DOM_PAGE : `FS_DOM_SECT;
      end
      else if (dom_entry == 2'b01) // manager entry 11 skips this
      begin
        if (!chk_is_page && !perm_ok(chk_l1_desc[11:10], chk_user, chk_is_write,
                                     control[`CTL_SYS_PROT], control[`CTL_ROM_PROT]))
        begin
          next_fault = 1'b1;
          next_code  = `FS_PERM_SECT;
        end
        else if (chk_is_page && !perm_ok(page_perm, chk_user, chk_is_write,
                                         control[`CTL_SYS_PROT], control[`CTL_ROM_PROT]))
        begin
          next_fault = 1'b1;
          next_code  = `FS_PERM_PAGE;
        end
      end
    end
  end

  // check answer, registered one cycle after the request; fault capture sits in the register block
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      chk_done       <= 1'b0;
      chk_abort      <= 1'b0;
      chk_fault_code <= 4'h0;
    end
    else
    begin
      chk_done       <= chk_valid;
      chk_abort      <= chk_valid && next_fault;
      chk_fault_code <= chk_valid ? next_code : 4'h0;
    end
  end

  // external abort handling by access class
  wire ext_hit     = ext_access && ext_abort;
  wire ext_restart = (ext_kind == `KIND_UNCACHED) || (ext_kind == `KIND_UNBUF_WR)
                     || (ext_kind == `KIND_L1_FETCH) || (ext_kind == `KIND_L2_FETCH)
                     || (ext_kind == `KIND_LOCKED_RD);
  reg [3:0] ext_code;
  always @*
  begin
    case (ext_kind)
      `KIND_L1_FETCH: ext_code = `FS_BUS_L1;
      `KIND_L2_FETCH: ext_code = `FS_BUS_L2;
      `KIND_LINEFILL: ext_code = `FS_LINE_SECT;
      `KIND_BUF_WR:   ext_code = `FS_WBUF;
      default:        ext_code = `FS_BUS_SECT;
    endcase
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      ext_stop          <= 1'b0;
      lock_write_block  <= 1'b0;
      cache_write_block <= 1'b0;
      wbuf_fatal        <= 1'b0;
    end
    else
    begin
      // line fills and buffered bursts never stop early
      ext_stop <= ext_hit && ext_restart;
      if (ext_hit && ext_kind == `KIND_LOCKED_RD)
        lock_write_block <= 1'b1;
      else if (ext_access && ext_kind != `KIND_LOCKED_RD)
        lock_write_block <= 1'b0;
      // only a word 0 abort is safe; later ones are the memory's fault
      if (ext_hit && ext_kind == `KIND_LINEFILL && ext_word == 2'b00)
        cache_write_block <= 1'b1;
      else if (ext_access && ext_kind != `KIND_LINEFILL)
        cache_write_block <= 1'b0;
      // sticky until reset: the core has already moved on
      if (ext_hit && ext_kind == `KIND_BUF_WR)
        wbuf_fatal <= 1'b1;
    end
  end

  // registers; enable ordering is left to software
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      control            <= `CONTROL_RESET;
      domain_word        <= `DOMAIN_RESET;
      fault_code         <= 4'h0;
      fault_domain       <= 4'h0;
      fault_address_word <= 32'h00000000;
      reg_rdata          <= 32'h00000000;
    end
    else
    begin
      if (reg_write && reg_addr == `ADDR_CONTROL)
        control <= reg_wdata;
      if (reg_write && reg_addr == `ADDR_DOMAIN_CTRL)
        domain_word <= reg_wdata;
      // fault capture wins over a software write in the same cycle
      if (chk_valid && next_fault && !chk_is_fetch) // fetches leave it alone
      begin
        fault_code         <= next_code;
        fault_domain       <= dom_sel;
        fault_address_word <= chk_vaddr;
      end
      else if (ext_hit)
      begin
        fault_code   <= ext_code;
        fault_domain <= ext_domain;
        if (ext_kind != `KIND_BUF_WR)
          fault_address_word <= ext_vaddr;
      end
      else if (reg_write && reg_addr == `ADDR_FAULT_STATUS)
      begin
        fault_code   <= reg_wdata[3:0];
        fault_domain <= reg_wdata[7:4];
      end
      else if (reg_write && reg_addr == `ADDR_FAULT_ADDR)
        fault_address_word <= reg_wdata;
      if (reg_read)
      begin
        case (reg_addr)
          `ADDR_CONTROL:      reg_rdata <= control;
          `ADDR_DOMAIN_CTRL:  reg_rdata <= domain_word;
          `ADDR_FAULT_STATUS: reg_rdata <= {24'h000000, fault_domain, fault_code};
          `ADDR_FAULT_ADDR:   reg_rdata <= fault_address_word;
          default:            reg_rdata <= 32'h00000000;
        endcase
      end
      else
        reg_rdata <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ==== verification/fault_rules_checker.sv ====
// assertions watching the access fault checker ports
`timescale 1ns/1ns
`default_nettype none
module fault_rules_checker
(
  // watched ports
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic chk_valid,
  input wire logic [31:0] chk_vaddr,
  input wire logic chk_is_fetch,
  input wire logic chk_is_byte,
  input wire logic chk_is_page,
  input wire logic [31:0] chk_l1_desc,
  input wire logic [31:0] chk_l2_desc,
  input wire logic chk_done,
  input wire logic chk_abort,
  input wire logic [3:0] chk_fault_code,
  input wire logic ext_access,
  input wire logic [2:0] ext_kind,
  input wire logic ext_abort,
  input wire logic [1:0] ext_word,
  input wire logic ext_stop,
  input wire logic lock_write_block,
  input wire logic cache_write_block,
  input wire logic wbuf_fatal
);
  // shadow words; loaded on the same edge as the block's control and domain registers
  logic [31:0] ctl, dom;
  wire [1:0] ent = dom[{chk_l1_desc[8:5], 1'h0} +: 2];
  wire mis = ctl[1] && !chk_is_fetch && !chk_is_byte && chk_vaddr[1:0] != 2'h0;
  wire l1ok = chk_l1_desc[1] ^ chk_l1_desc[0];
  wire xok = l1ok && (!chk_is_page || (chk_l2_desc[1] ^ chk_l2_desc[0]));
  wire ck = chk_valid && ctl[0] && !mis;
  wire ab = ext_access && ext_abort;
  always @(posedge clock)
  begin
    ctl <= !rst_n ? 32'h0 : (reg_write && reg_addr == 4'h0) ? reg_wdata : ctl;
    dom <= !rst_n ? 32'h0 : (reg_write && reg_addr == 4'h1) ? reg_wdata : dom;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  align_fault_a: assert property (chk_valid && mis |=> chk_abort && chk_fault_code == 4'h1)
    else $error("bad alignment answer");
  sect_xlat_a: assert property (ck && !l1ok |=> chk_abort && chk_fault_code == 4'h5)
    else $error("bad section translation answer");
  page_xlat_a: assert property (ck && chk_is_page && l1ok && !xok |=> chk_fault_code == 4'h7)
    else $error("bad page translation answer");
  domain_fault_a: assert property (ck && xok && !ent[0] |=> chk_fault_code == ($past(chk_is_page) ? 4'hb : 4'h9))
    else $error("bad domain answer");
  manager_pass_a: assert property (ck && xok && ent == 2'h3 |=> !chk_abort)
    else $error("manager access faulted");
  perm_client_a: assert property (chk_done && chk_fault_code[3:2] == 2'h3 && chk_fault_code[0] |-> $past(ent) == 2'h1 && $past(chk_is_page) == chk_fault_code[1])
    else $error("permission fault outside client");
  ext_stop_a: assert property (ab && ext_kind <= 3'h4 |=> ext_stop && lock_write_block == ($past(ext_kind) == 3'h4))
    else $error("bad restartable abort");
  fill_abort_a: assert property (ab && ext_kind == 3'h5 && ext_word == 2'h0 |=> cache_write_block && !ext_stop)
    else $error("bad line fill abort");
  buffered_fatal_a: assert property (ab && ext_kind == 3'h6 || wbuf_fatal |=> wbuf_fatal && !ext_stop)
    else $error("bad buffered write abort");
endmodule
bind mmu_fault_checker fault_rules_checker fault_rules_checker_i (.*);
`default_nettype wire

// ==== verification/mem_abort_model.sv ====
// far side memory model: bus words with an external abort on the first word
`timescale 1ns/1ns
`default_nettype none
module mem_abort_model
(
  // request from the bench
  input wire logic clock,
  input wire logic start,
  input wire logic [2:0] kind,
  input wire logic [1:0] last_word,
  // bus words towards the block
  output var logic ext_access = 0,
  output var logic [2:0] ext_kind = 3'h0,
  output var logic ext_abort = 0,
  output var logic [1:0] ext_word = 2'h0
);
  // a burst runs on to its last word after the abort; the index keeps moving while idle
  always @(posedge clock)
  begin
    ext_access <= start || (ext_access && ext_word != last_word);
    ext_abort <= start;
    ext_word <= start ? 2'h0 : ext_word + 2'h1;
    ext_kind <= start ? kind : ext_kind;
  end
endmodule
`default_nettype wire

// ==== verification/mmu_fault_checker_bench.sv ====
// self-checking bench for the access fault checker
`timescale 1ns/1ns
`default_nettype none
module mmu_fault_checker_bench;
  logic clock = 0, rst_n = 0, reg_write = 0, reg_read = 0, chk_valid = 0, start = 0;
  logic chk_is_fetch = 0, chk_is_byte = 0, chk_is_write = 0, chk_user = 0;
  logic chk_is_page = 0, chk_large_page = 0;
  logic [3:0] reg_addr = 4'h0, ext_domain = 4'h5;
  logic [31:0] reg_wdata = 32'h0, chk_vaddr = 32'h0, chk_l1_desc = 32'h0, chk_l2_desc = 32'h0;
  logic [31:0] ext_vaddr = 32'h4440;
  logic [2:0] kind = 3'h0;
  logic [1:0] last_word = 2'h0;
  wire chk_done, chk_abort, ext_access, ext_abort, ext_stop, lock_write_block, tlb_keep;
  wire cache_write_block, wbuf_fatal, mmu_enable, cache_enable, write_buffer_enable;
  wire [31:0] reg_rdata;
  wire [3:0] chk_fault_code;
  wire [2:0] ext_kind;
  wire [1:0] ext_word;
  int fails = 0, num_checks = 0;
  logic [3:0] fs [6] = '{4'h8, 4'h8, 4'hc, 4'he, 4'h8, 4'h4};
  mmu_fault_checker mmu_fault_checker_i (.*);
  mem_abort_model mem_abort_model_i (.*);
  always #4 clock = ~clock;
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_read <= 1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 0;
    #1 check("register", reg_rdata, exp);
  endtask
  // f holds fetch, byte, write, user, page, large from the top down
  task automatic acc(input logic [31:0] va, input logic [5:0] f, input logic [3:0] dm,
                     input logic [1:0] pb, t1, input logic [11:0] l2, input logic [3:0] code);
    @(posedge clock);
    chk_valid <= 1;
    chk_vaddr <= va;
    {chk_is_fetch, chk_is_byte, chk_is_write, chk_user, chk_is_page, chk_large_page} <= f;
    chk_l1_desc <= {20'h0, pb, 1'h0, dm, 3'h0, t1};
    chk_l2_desc <= {20'h0, l2};
    @(posedge clock);
    chk_valid <= 0;
    #1 check("answer", {chk_done, chk_abort, chk_fault_code}, {1'h1, code != 4'h0, code});
  endtask
  task automatic bus(input logic [2:0] k);
    @(posedge clock);
    start <= 1;
    kind <= k;
    last_word <= k > 3'h4 ? 2'h3 : 2'h0;
    @(posedge clock);
    start <= 0;
    repeat (6) @(posedge clock);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // whole run is well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clock);
    fails++;
    end_of_test;
  end
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1;
    rd(4'h0, 32'h0);
    rd(4'h7, 32'h0);
    wr(4'h0, 32'h2);
    acc(32'h1001, 6'h00, 4'h0, 2'h0, 2'h0, 12'h0, 4'h1);
    acc(32'h1001, 6'h20, 4'h0, 2'h0, 2'h0, 12'h0, 4'h0);
    acc(32'h1003, 6'h10, 4'h0, 2'h0, 2'h0, 12'h0, 4'h0);
    rd(4'h2, 32'h1);
    rd(4'h3, 32'h1001);
    wr(4'h1, 32'h2c4);
    wr(4'h0, 32'h3);
    acc(32'h2000, 6'h00, 4'h1, 2'h3, 2'h0, 12'h0, 4'h5);
    acc(32'h2000, 6'h00, 4'h1, 2'h3, 2'h3, 12'h0, 4'h5);
    acc(32'h2002, 6'h00, 4'h1, 2'h3, 2'h0, 12'h0, 4'h1);
    acc(32'h2000, 6'h00, 4'h2, 2'h3, 2'h2, 12'h0, 4'h9);
    acc(32'h2000, 6'h00, 4'h4, 2'h3, 2'h2, 12'h0, 4'h9);
    acc(32'h2000, 6'h0c, 4'h3, 2'h0, 2'h2, 12'h0, 4'h0);
    acc(32'h2000, 6'h04, 4'h1, 2'h1, 2'h2, 12'h0, 4'hd);
    acc(32'h2000, 6'h0c, 4'h1, 2'h2, 2'h2, 12'h0, 4'hd);
    acc(32'h2000, 6'h04, 4'h1, 2'h2, 2'h2, 12'h0, 4'h0);
    acc(32'h2000, 6'h00, 4'h1, 2'h0, 2'h2, 12'h0, 4'hd);
    acc(32'h3000, 6'h20, 4'h1, 2'h0, 2'h0, 12'h0, 4'h5);
    rd(4'h2, 32'h1d);
    rd(4'h3, 32'h2000);
    acc(32'h4000, 6'h02, 4'h1, 2'h0, 2'h1, 12'hc03, 4'h7);
    acc(32'h4000, 6'h02, 4'h2, 2'h0, 2'h1, 12'hc02, 4'hb);
    acc(32'h4c00, 6'h06, 4'h1, 2'h0, 2'h1, 12'hc02, 4'h0);
    acc(32'h4000, 6'h06, 4'h1, 2'h0, 2'h1, 12'hc02, 4'hf);
    acc(32'h4400, 6'h06, 4'h1, 2'h0, 2'h2, 12'h0f2, 4'h0);
    acc(32'h4800, 6'h06, 4'h1, 2'h0, 2'h2, 12'h0f2, 4'hf);
    acc(32'hc000, 6'h07, 4'h1, 2'h0, 2'h1, 12'hc01, 4'h0);
    acc(32'h0c00, 6'h07, 4'h1, 2'h0, 2'h1, 12'hc01, 4'hf);
    rd(4'h2, 32'h1f);
    wr(4'h0, 32'h103);
    acc(32'h2000, 6'h00, 4'h1, 2'h0, 2'h2, 12'h0, 4'h0);
    wr(4'h0, 32'hf);
    check("enables", {mmu_enable, cache_enable, write_buffer_enable}, 3'h7);
    wr(4'h0, 32'h7);
    wr(4'h0, 32'h3);
    wr(4'h0, 32'h2);
    check("enables", {mmu_enable, cache_enable, write_buffer_enable, tlb_keep}, 4'h1);
    for (int k = 0; k < 6; k++)
    begin
      bus(k[2:0]);
      rd(4'h2, {24'h0, ext_domain, fs[k]});
      check("blocks", {lock_write_block, cache_write_block}, {k == 4, k == 5});
    end
    bus(3'h6);
    check("fatal", wbuf_fatal, 1'h1);
    rst_n <= 0;
    repeat (2) @(posedge clock);
    rst_n <= 1;
    #1 check("fatal", wbuf_fatal, 1'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
